// ### src/stack_push_sequencer.sv
// Execution sequencer for push-all and push-flags instructions.
`timescale 1ns/1ns
module stack_push_sequencer #(
  parameter int WORD_W = push_seq_pkg::WORD_W
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clock_en,
  input  wire logic              push_all_registers,
  input  wire logic              push_flag_word,
  input  wire logic [WORD_W-1:0] accumulator,
  input  wire logic [WORD_W-1:0] count_register,
  input  wire logic [WORD_W-1:0] data_register,
  input  wire logic [WORD_W-1:0] base_register,
  input  wire logic [WORD_W-1:0] stack_pointer,
  input  wire logic [WORD_W-1:0] base_pointer,
  input  wire logic [WORD_W-1:0] source_index,
  input  wire logic [WORD_W-1:0] destination_index,
  input  wire logic [WORD_W-1:0] flag_word,
  input  wire logic              mem_ready,
  output logic                   busy,
  output logic                   done,
  output logic                   mem_write,
  output logic [WORD_W-1:0]      mem_addr,
  output logic [7:0]             mem_data_low,
  output logic [7:0]             mem_data_high,
  output logic [WORD_W-1:0]      mem_addr_high,
  output logic                   stack_pointer_we,
  output logic [WORD_W-1:0]      stack_pointer_new
);

  // Only a 16-bit word splits evenly into the two byte lanes of the bus.
  if (WORD_W != 16)
  begin : g_bad_width
    $error("stack_push_sequencer: word width must be 16");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  push_seq_pkg::seq_state_t state_q;
  push_seq_pkg::seq_state_t state_d;
  logic [WORD_W-1:0]        sp_q;
  logic [WORD_W-1:0]        sp_d;
  logic [2:0]               slot_q;
  logic [2:0]               slot_d;
  logic                     is_all_q;
  logic [WORD_W-1:0]        flags_q;
  logic [WORD_W-1:0]        snap_data;
  logic [8*WORD_W-1:0]      snap_words;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // State test shared by the request, bus and status decodes below.
  function automatic logic in_state(input push_seq_pkg::seq_state_t cur,
                                    input push_seq_pkg::seq_state_t want);
    in_state = (cur == want);
  endfunction : in_state

  // Requests are taken only in idle; push-all wins when both are high.
  wire in_idle     = in_state(state_q, push_seq_pkg::ST_IDLE);
  wire start_all   = in_idle && push_all_registers;
  wire start_flags = in_idle && !push_all_registers && push_flag_word;
  // Push-flags is a single word, so its first slot is also its last.
  wire last_slot   = !is_all_q || (slot_q == push_seq_pkg::SLOT_LAST);
  // The bus word launches from WRITE and is retired by the memory in WAIT.
  wire issue_write = in_state(state_q, push_seq_pkg::ST_WRITE);
  wire word_taken  = in_state(state_q, push_seq_pkg::ST_WAIT) && mem_ready;
  wire seq_end     = word_taken && last_slot;
  wire [WORD_W-1:0] sp_lowered = sp_q - push_seq_pkg::PUSH_STEP;
  wire [WORD_W-1:0] word_out   = is_all_q ? snap_data : flags_q;

  // The snapshot, not the live inputs, feeds every push-all word.
  // fixed save order
  assign snap_words = {destination_index, source_index, base_pointer, stack_pointer,
                       base_register, data_register, count_register, accumulator};

  // Snapshot memory; read index follows the slot counter.
  push_snapshot #(
    .WIDTH (WORD_W),
    .DEPTH (push_seq_pkg::REG_COUNT),
    .AW    (push_seq_pkg::IDX_W)
  ) u_snapshot (
    .clock      (clock),
    .clock_en   (clock_en),
    .load       (start_all),
    .load_words (snap_words),
    .read_index (slot_q),
    .read_data  (snap_data)
  );

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  // DECR lowers the pointer and gives the snapshot a cycle to read.
  // Nothing here waits on a counter; each word costs DECR, WRITE and one WAIT or more.
  always_comb
  begin
    state_d = state_q;
    sp_d    = sp_q;
    slot_d  = slot_q;
    case (state_q)
      push_seq_pkg::ST_IDLE:
      begin
        // The slot counter is parked at the first word so the snapshot read is primed.
        slot_d = push_seq_pkg::SLOT_ACCUM;
        if (start_all || start_flags)
        begin
          sp_d    = stack_pointer;
          state_d = push_seq_pkg::ST_DECR;
        end
      end
      push_seq_pkg::ST_DECR:
      begin
        sp_d    = sp_lowered;
        state_d = push_seq_pkg::ST_WRITE;
      end
      push_seq_pkg::ST_WRITE:
      begin
        // The bus registers load on this edge; the pointer holds its value.
        state_d = push_seq_pkg::ST_WAIT;
      end
      push_seq_pkg::ST_WAIT:
      begin
        // Stay here until the memory takes the word; there is no time-out.
        if (mem_ready)
        begin
          if (last_slot)
            state_d = push_seq_pkg::ST_IDLE;
          else
          begin
            slot_d  = slot_q + 3'h1;
            state_d = push_seq_pkg::ST_DECR;
          end
        end
      end
      default:
        state_d = push_seq_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer core; the flag word is latched at start and never written back.
  // Every register here holds while clock_en is low, so a frozen sequence resumes intact.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q  <= push_seq_pkg::ST_IDLE;
      sp_q     <= push_seq_pkg::WORD_RESET;
      slot_q   <= push_seq_pkg::SLOT_ACCUM;
      is_all_q <= 1'b0;
      flags_q  <= push_seq_pkg::WORD_RESET;
    end
    else if (clock_en)
    begin
      state_q <= state_d;
      sp_q    <= sp_d;
      slot_q  <= slot_d;
      if (start_all || start_flags)
      begin
        is_all_q <= start_all;
        flags_q  <= flag_word;
      end
    end
  end

  // Bus write outputs, registered; held until the memory answers.
  // A ready that arrives while clock_en is low is not seen; the memory must hold it.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mem_write     <= 1'b0;
      mem_addr      <= push_seq_pkg::WORD_RESET;
      mem_addr_high <= push_seq_pkg::WORD_RESET;
      mem_data_low  <= 8'h00;
      mem_data_high <= 8'h00;
    end
    else if (clock_en)
    begin
      if (issue_write)
      begin
        mem_write     <= 1'b1;
        mem_addr      <= sp_q;
        mem_addr_high <= sp_q + push_seq_pkg::HIGH_BYTE_OFS;
        mem_data_low  <= word_out[7:0];
        mem_data_high <= word_out[15:8];
      end
      else if (word_taken)
        mem_write <= 1'b0;
    end
  end

  // Status and final pointer update to the register file.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy              <= 1'b0;
      done              <= 1'b0;
      stack_pointer_we  <= 1'b0;
      stack_pointer_new <= push_seq_pkg::WORD_RESET;
    end
    else if (clock_en)
    begin
      busy             <= (state_d != push_seq_pkg::ST_IDLE);
      done             <= 1'b0;
      stack_pointer_we <= 1'b0;
      if (seq_end)
      begin
        done              <= 1'b1;
        stack_pointer_we  <= 1'b1;
        stack_pointer_new <= sp_q;
      end
    end
  end

endmodule : stack_push_sequencer

// ### include/push_seq_pkg.sv
// Constants and types shared by the stack push sequencer.
// Operation
// - Push-all saves eight registers fixed order.
// - Stack pointer slot holds pre-instruction value.
// - Each push lowers pointer two, then writes.
// - Push-flags lowers pointer two, writes flags.
// - Low byte at address, high at plus one.
// - No flag changes during either push.
package push_seq_pkg;

  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int          WORD_W        = 16;
  localparam int          REG_COUNT     = 8;
  localparam int          IDX_W         = 3;
  localparam logic [15:0] PUSH_STEP     = 16'h0002;
  localparam logic [15:0] WORD_RESET    = 16'h0000;
  localparam logic [15:0] HIGH_BYTE_OFS = 16'h0001;

  // Slot numbers in push-all order.
  localparam logic [2:0] SLOT_ACCUM     = 3'h0;
  localparam logic [2:0] SLOT_COUNT     = 3'h1;
  localparam logic [2:0] SLOT_DATA      = 3'h2;
  localparam logic [2:0] SLOT_BASE      = 3'h3;
  localparam logic [2:0] SLOT_STACK_PTR = 3'h4;
  localparam logic [2:0] SLOT_BASE_PTR  = 3'h5;
  localparam logic [2:0] SLOT_SRC_IDX   = 3'h6;
  localparam logic [2:0] SLOT_DST_IDX   = 3'h7;
  localparam logic [2:0] SLOT_LAST      = 3'h7;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DECR,
    ST_WRITE,
    ST_WAIT
  } seq_state_t;

endpackage : push_seq_pkg

// ### src/push_snapshot.sv
// Eight-word snapshot memory holding registers for push-all.
`timescale 1ns/1ns
module push_snapshot #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic                   clock,
  input  wire logic                   clock_en,
  input  wire logic                   load,
  input  wire logic [DEPTH*WIDTH-1:0] load_words,
  input  wire logic [AW-1:0]          read_index,
  output logic      [WIDTH-1:0]       read_data
);

  // A depth beyond the index range would leave slots that no read can reach.
  if (DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("push_snapshot: depth exceeds address range");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------
  // All slots load at once so later pointer updates cannot leak in.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_slot
      always_ff @(posedge clock)
      begin
        if (clock_en && load)
          mem_q[g] <= load_words[g*WIDTH +: WIDTH];
      end
    end
  endgenerate

  // Read data comes from a register, one cycle after the index.
  always_ff @(posedge clock)
  begin
    if (clock_en)
      read_data <= mem_q[read_index];
  end

endmodule : push_snapshot

// ### testbench/stack_mem_model.sv
// Stack memory model that accepts each write after a random stall.
`timescale 1ns/1ns
module stack_mem_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic mem_write,
  output logic      mem_ready
);
  int wait_q;
  // Ready is a one-cycle accept; a stall of 0 to 2 cycles exposes early sampling.
  always @(posedge clock)
  begin
    if (rst)
    begin
      mem_ready <= 1'b0;
      wait_q    <= 0;
    end
    else
    begin
      if (mem_write && !mem_ready && wait_q == 0) mem_ready <= 1'b1;
      else mem_ready <= 1'b0;
      if (!mem_write || mem_ready) wait_q <= $urandom_range(2, 0);
      else if (wait_q != 0) wait_q <= wait_q - 1;
    end
  end
endmodule : stack_mem_model

// ### testbench/stack_push_sequencer_sva.sv
// Port checker for the stack push sequencer.
`timescale 1ns/1ns
module push_seq_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        push_flag_word,
  input wire logic        mem_ready,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_addr_high,
  input wire logic        stack_pointer_we
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_high_addr; mem_write |-> mem_addr_high == mem_addr + 16'h0001; endproperty
  a_high_addr: assert property (p_high_addr) else $error("high address off");
  property p_hold; mem_write && !mem_ready |=> mem_write && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("write dropped early");
  property p_release; mem_write && mem_ready |=> !mem_write; endproperty
  a_release: assert property (p_release) else $error("write held on");
  property p_start; !busy && push_flag_word |=> busy; endproperty
  a_start: assert property (p_start) else $error("request not taken");
  property p_first; $rose(busy) |-> !mem_write ##2 mem_write; endproperty
  a_first: assert property (p_first) else $error("first write late");
  property p_we; done |-> stack_pointer_we && !busy; endproperty
  a_we: assert property (p_we) else $error("pointer update missing");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_quiet; !busy |-> !mem_write; endproperty
  a_quiet: assert property (p_quiet) else $error("write while idle");
  c_done: cover property (done);
  c_stall: cover property (mem_write && !mem_ready);
  c_busy_req: cover property (busy && push_flag_word);
endmodule : push_seq_sva
bind stack_push_sequencer push_seq_sva u_sva (.clock, .rst, .push_flag_word, .mem_ready,
  .busy, .done, .mem_write, .mem_addr, .mem_addr_high, .stack_pointer_we);

// ### testbench/stack_push_sequencer_bench.sv
// Self-checking bench for the stack push sequencer.
`timescale 1ns/1ns
module stack_push_sequencer_bench;
  logic clock, rst, clock_en, push_all_registers, push_flag_word, mem_ready;
  logic busy, done, mem_write, stack_pointer_we;
  logic [15:0] regs [8];
  logic [15:0] flag_word, mem_addr, mem_addr_high, stack_pointer_new;
  logic [7:0]  mem_data_low, mem_data_high;
  logic [31:0] exp_q [$];
  logic [15:0] sp_q [$];
  int          miscompares = 0;
  int          tests_run = 0;
  int          n;
  logic [31:0] want_w;
  stack_push_sequencer u_dut (.clock, .rst, .clock_en, .push_all_registers,
    .push_flag_word, .accumulator(regs[0]), .count_register(regs[1]),
    .data_register(regs[2]), .base_register(regs[3]), .stack_pointer(regs[4]),
    .base_pointer(regs[5]), .source_index(regs[6]), .destination_index(regs[7]),
    .flag_word, .mem_ready, .busy, .done, .mem_write, .mem_addr, .mem_data_low,
    .mem_data_high, .mem_addr_high, .stack_pointer_we, .stack_pointer_new);
  stack_mem_model u_mem (.clock, .rst, .mem_write, .mem_ready);
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task final_report;
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Notes the words and final pointer, then requests; push-all also raises flags.
  task automatic run_push(input bit all);
    int i;
    logic [15:0] sp;
    for (i = 0; i < 8; i++) regs[i] = 16'($urandom);
    flag_word = 16'($urandom);
    sp = regs[4];
    if (all) for (i = 0; i < 8; i++) exp_q.push_back({sp - 16'(2 * i + 2), regs[i]});
    else exp_q.push_back({sp - 16'h0002, flag_word});
    sp_q.push_back(all ? sp - 16'h0010 : sp - 16'h0002);
    push_all_registers = all;
    push_flag_word = 1'b1;
    @(posedge clock) #2;
    {push_all_registers, push_flag_word} = 2'b00;
    // Inputs move after the start edge; only the captured values may reach the bus.
    for (i = 0; i < 8; i++) regs[i] = 16'($urandom);
    flag_word = 16'($urandom);
    @(posedge clock) #2;
    push_flag_word = 1'b1; // Ignored while busy.
    @(posedge clock) #2;
    push_flag_word = 1'b0;
    for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge clock) #2;
    @(posedge clock) #2;
  endtask : run_push
  always @(posedge clock)
  begin
    if (mem_write === 1'b1 && mem_ready === 1'b1)
    begin
      want_w = exp_q.size() ? exp_q.pop_front() : 'x;
      check({mem_addr, mem_data_high, mem_data_low}, want_w);
    end
    if (done === 1'b1) check(stack_pointer_new, sp_q.size() ? sp_q.pop_front() : 'x);
  end
  initial
  begin
    {rst, clock_en} = 2'b11;
    {push_all_registers, push_flag_word} = 2'b00;
    regs = '{default: 16'h0000};
    flag_word = 16'h0000;
    void'($urandom(32'hD154));
    repeat (2) @(posedge clock);
    #2 rst = 1'b0;
    for (n = 0; n < 12; n++) run_push(n[0]);
    check(exp_q.size() + sp_q.size(), 0);
    final_report();
  end
  initial
  begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule : stack_push_sequencer_bench
